// ==== verilog/host_port_defs.svh ====
// constants for the half-duplex host serial port
// assumes a 50 MHz core clock; included by bare name
`ifndef HOST_PORT_DEFS_SVH
`define HOST_PORT_DEFS_SVH
`define CLK_HZ          50000000
`define BAUD_4800       4800
`define BAUD_9600       9600
`define BAUD_19200      19200
`define BAUD_38400      38400
`define BIT_DIV(b)      ((`CLK_HZ + (b) / 2) / (b))
`define DIV_W           16
`define DATA_BITS       8
`define BIT_CNT_W       4
`define RATE_4800       2'h0
`define RATE_9600       2'h1
`define RATE_19200      2'h2
`define RATE_38400      2'h3
`endif

// ==== verilog/host_port_pkg.sv ====
// types for the half-duplex host serial port
// assumes host_port_defs.svh is compiled alongside
package host_port_pkg;
  typedef enum logic [1:0] {IDLE, TX_BUSY, RX_BUSY} port_state_t;
endpackage

// ==== verilog/baud_tick_gen.sv ====
// baud tick generator: one-cycle enables at the bit rate and at its half
// assumes the divisor is stable while enable is high
`timescale 1ns/1ps
`include "host_port_defs.svh"
module baud_tick_gen (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  // control
  input  wire logic              run,
  input  wire logic [`DIV_W-1:0] divisor,
  // ticks
  output logic                   bitTick,
  output logic                   halfTick
);
  typedef struct packed {
    logic [`DIV_W-1:0] cnt;
    logic              bitT;
    logic              halfT;
  } tick_state_t;

  tick_state_t st_r;
  tick_state_t st_nxt;

  // count a bit period, restart whenever idle
  always_comb begin
    st_nxt       = st_r;
    st_nxt.bitT  = 1'b0;
    st_nxt.halfT = 1'b0;
    if (!run) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt == divisor - `DIV_W'(1)) begin
      st_nxt.cnt  = '0;
      st_nxt.bitT = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + `DIV_W'(1);
      if (st_r.cnt == (divisor >> 1)) begin
        st_nxt.halfT = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bitTick  = st_r.bitT;
  assign halfTick = st_r.halfT;
endmodule

// ==== verilog/host_serial_port.sv ====
// half-duplex asynchronous serial port facing the application controller
// assumes all inputs synchronous to core_clk; open-drain line resolved outside
// Notes on behaviour
// - the port is half duplex with plain asynchronous framing.
// - the two rate straps pick 4800, 9600, 19200 or 38400 bit/s.
// - the straps are caught only as a hardware or software reset or test mode ends and then held.
// - strap changes in normal running never touch the active rate.
// - the port is held in reset while master_reset_n is low and runs once it is high with softReset and testEnable low.
// - normal behaviour needs testEnable low; the pull-down lives in the pad.
// - the port sends on its transmit line and listens on its receive line.
// - the transmit line only pulls low for zero and releases for one.
// - all bit timing comes from the single core clock.
`timescale 1ns/1ps
`include "host_port_defs.svh"
module host_serial_port
  import host_port_pkg::*;
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       master_reset_n,
  input  wire logic       softReset,
  input  wire logic       testEnable,
  // rate straps
  input  wire logic       rate_select_high,
  input  wire logic       rate_select_low,
  // serial line
  input  wire logic       serialIn,
  output logic            serialOut,
  output logic            serialOutEn,
  // transmit side
  input  wire logic       txValid,
  input  wire logic [7:0] txData,
  output logic            txReady,
  // receive side
  output logic            rxValid,
  output logic [7:0]      rxData,
  output logic            rxFrameErr,
  output logic [1:0]      activeRate
);
  typedef struct packed {
    port_state_t     state;
    logic [1:0]      rate;
    logic            capture;
    logic [`BIT_CNT_W-1:0] bitCnt;
    logic [9:0]      shift;
    logic            lineLow;
    logic            ready;
    logic            rxV;
    logic [7:0]      rxD;
    logic            rxErr;
  } port_reg_t;

  port_reg_t st_r;
  port_reg_t st_nxt;
  logic [`DIV_W-1:0] divisor;
  logic              tickRun;
  logic              bitTick;
  logic              halfTick;
  logic              rxSampled;
  logic              active;
  logic              txTake;
  logic              rxStart;
  logic              lastBit;
  logic              stopSeen;

  // reset sources: reset_n clears every register but sets the capture flag, while
  // master_reset_n, softReset and testEnable are level inputs that only
  // hold the port idle; the straps are taken on the first cycle after all
  // three have let go, so a host that moves the straps must pulse one of
  // them afterwards or the old rate stays in force
  // testEnable high is treated like a reset: the port goes quiet, the line
  // is released and no byte is accepted until it drops again
  // port runs only outside reset and outside test mode
  assign active = master_reset_n && !softReset && !testEnable;

  // divisors are rounded to the nearest whole core cycle; the error this
  // leaves is far below what a plain receiver on the far side tolerates
  // the divisor reads the captured code, never the strap pins, so a strap
  // that wanders mid-frame cannot stretch or shrink a bit
  // strap code to bit divisor, all from core_clk
  always_comb begin
    case (st_r.rate)
      `RATE_4800:  divisor = `DIV_W'(`BIT_DIV(`BAUD_4800));
      `RATE_9600:  divisor = `DIV_W'(`BIT_DIV(`BAUD_9600));
      `RATE_19200: divisor = `DIV_W'(`BIT_DIV(`BAUD_19200));
      `RATE_38400: divisor = `DIV_W'(`BIT_DIV(`BAUD_38400));
      default:     divisor = `DIV_W'(`BIT_DIV(`BAUD_4800));
    endcase
  end

  assign tickRun = (st_r.state != IDLE);

  baud_tick_gen u_ticks (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .run      (tickRun),
    .divisor  (divisor),
    .bitTick  (bitTick),
    .halfTick (halfTick)
  );

  // receive line is looked at only when not transmitting
  // forcing it high while sending means an echo or a host that talks over
  // the port can neither start a receive nor corrupt one in progress
  assign rxSampled = (st_r.state == TX_BUSY) ? 1'b1 : serialIn;

  // handshake and framing events, named once for the state machine
  assign txTake   = txValid && st_r.ready;
  assign rxStart  = !rxSampled;
  assign lastBit  = (st_r.bitCnt == `BIT_CNT_W'(`DATA_BITS + 1));
  assign stopSeen = rxSampled;

  // next-state logic for framing and strap capture
  // one state machine serves both directions, so a transmit can never start
  // while a receive runs and the other way round; a transmit request wins
  // when both arrive in the same idle cycle
  // the bit counter counts start, eight data bits and stop; the frame ends
  // on the tick that closes the stop bit, so txReady returns only after the
  // full stop time has been on the line
  always_comb begin
    st_nxt     = st_r;
    st_nxt.rxV = 1'b0;
    if (!active) begin
      st_nxt.state   = IDLE;
      st_nxt.capture = 1'b1;
      st_nxt.lineLow = 1'b0;
      st_nxt.ready   = 1'b0;
      st_nxt.bitCnt  = '0;
    end else if (st_r.capture) begin
      // first active cycle after reset: take the straps once
      st_nxt.rate    = {rate_select_high, rate_select_low};
      st_nxt.capture = 1'b0;
      st_nxt.ready   = 1'b1;
    end else begin
      case (st_r.state)
        IDLE: begin
          if (txTake) begin
            st_nxt.shift   = {1'b1, txData, 1'b0};
            st_nxt.state   = TX_BUSY;
            st_nxt.ready   = 1'b0;
            st_nxt.bitCnt  = '0;
            st_nxt.lineLow = 1'b1;
          end else if (rxStart) begin
            st_nxt.state  = RX_BUSY;
            st_nxt.ready  = 1'b0;
            st_nxt.bitCnt = '0;
          end
        end
        TX_BUSY: begin
          // each bit tick moves the next bit onto the line
          if (bitTick) begin
            if (lastBit) begin
              st_nxt.state   = IDLE;
              st_nxt.ready   = 1'b1;
              st_nxt.lineLow = 1'b0;
            end else begin
              st_nxt.shift   = {1'b1, st_r.shift[9:1]};
              st_nxt.lineLow = !st_r.shift[1];
              st_nxt.bitCnt  = st_r.bitCnt + `BIT_CNT_W'(1);
            end
          end
        end
        RX_BUSY: begin
          // sample at mid-bit; a start that is high again by then was a glitch
          if (halfTick) begin
            if (st_r.bitCnt == '0 && rxSampled) begin
              st_nxt.state = IDLE; // false start
              st_nxt.ready = 1'b1;
            end else if (lastBit) begin
              st_nxt.rxD   = st_r.shift[9:2];
              st_nxt.rxErr = !stopSeen; // stop bit must be high
              st_nxt.rxV   = 1'b1;
              st_nxt.state = IDLE;
              st_nxt.ready = 1'b1;
            end else begin
              st_nxt.shift  = {rxSampled, st_r.shift[9:1]};
              st_nxt.bitCnt = st_r.bitCnt + `BIT_CNT_W'(1);
            end
          end
        end
        default: begin
          st_nxt.state = IDLE;
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r         <= '0;
      st_r.state   <= IDLE;
      st_r.capture <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register; the line itself is only ever
  // pulled low through the enable, its high level belongs to the pull-up
  assign serialOut   = 1'b0; // open drain drives low only
  assign serialOutEn = st_r.lineLow;
  assign txReady     = st_r.ready;
  assign rxValid     = st_r.rxV;
  assign rxData      = st_r.rxD;
  assign rxFrameErr  = st_r.rxErr;
  assign activeRate  = st_r.rate;
endmodule

// ==== verification/host_port_monitor.sv ====
// checker for the host serial port: line timing, rate capture, half duplex
// assumes it is bound onto host_serial_port; the line is low while serialOutEn is high
`timescale 1ns/1ps
module host_port_monitor (
  input wire logic       core_clk, reset_n, master_reset_n, softReset, testEnable,
  input wire logic       rate_select_high, rate_select_low, serialIn, serialOut,
  input wire logic       serialOutEn, txValid, txReady, rxValid,
  input wire logic [1:0] activeRate
);
  logic        run;
  logic [1:0]  settle_r;
  logic        txBusy_r;
  logic [17:0] busyCnt_r;
  int          div;
  assign run = master_reset_n && !softReset && !testEnable;
  assign div = activeRate == 2'h0 ? 10417 : activeRate == 2'h1 ? 5208 :
               activeRate == 2'h2 ? 2604 : 1302;
  // active cycles since release, transmit busy flag and its length
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      settle_r <= 2'h0;
      txBusy_r <= 1'b0;
      busyCnt_r <= 18'h0;
    end else begin
      settle_r <= !run ? 2'h0 : (settle_r == 2'h3 ? settle_r : settle_r + 2'h1);
      txBusy_r <= (txValid && txReady && run) || (txBusy_r && !txReady);
      busyCnt_r <= txBusy_r ? busyCnt_r + 18'h1 : 18'h0;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_drain_only: assert property (!serialOut)
    else $error("transmit data driven high");
  a_tx_start: assert property (txValid && txReady && run && serialIn |=> serialOutEn && !txReady)
    else $error("start bit missing after take");
  a_rate_capture: assert property (settle_r == 2'h1 |-> activeRate == $past({rate_select_high, rate_select_low}))
    else $error("straps not captured");
  a_rate_held: assert property (settle_r >= 2'h2 |-> $stable(activeRate))
    else $error("rate changed in operation");
  a_hold_idle: assert property (!run |=> !serialOutEn && !txReady)
    else $error("port active in reset or test");
  a_rx_quiet_tx: assert property (txBusy_r |-> !rxValid)
    else $error("receive during transmit");
  a_rx_pulse: assert property (rxValid |=> !rxValid)
    else $error("rxValid longer than one cycle");
  a_idle_high: assert property (txReady |-> !serialOutEn)
    else $error("line low while idle");
  a_frame_len: assert property ($rose(txReady) && txBusy_r |-> busyCnt_r >= 10 * div - 1 && busyCnt_r <= 10 * div + 3)
    else $error("frame length wrong for rate");
endmodule
bind host_serial_port host_port_monitor host_port_monitor_i (.core_clk, .reset_n,
  .master_reset_n, .softReset, .testEnable, .rate_select_high, .rate_select_low, .serialIn,
  .serialOut, .serialOutEn, .txValid, .txReady, .rxValid, .activeRate);

// ==== verification/host_uart_model.sv ====
// host controller model: sends and receives one-start, eight-data, one-stop characters
// assumes line is the resolved open-drain line, DIV core cycles per bit
`timescale 1ns/1ps
module host_uart_model #(parameter int DIV = 1302) (
  input  wire logic  core_clk,
  input  wire logic  line,
  output logic       serialIn,
  output logic [7:0] gotByte,
  output int         gotCnt
);
  initial serialIn = 1'b1;
  // send a character, lsb first, returning to idle high
  task automatic send(input logic [7:0] b);
    for (int i = 0; i < 10; i++) begin
      serialIn = i == 0 ? 1'b0 : i == 9 ? 1'b1 : b[i-1];
      repeat (DIV) @(negedge core_clk);
    end
  endtask
  // sample each bit at its middle after a start edge
  initial begin
    gotCnt = 0;
    gotByte = 8'h00;
    forever begin
      @(negedge line);
      repeat (DIV / 2) @(posedge core_clk);
      for (int i = 0; i < 8; i++) begin
        repeat (DIV) @(posedge core_clk);
        gotByte[i] = line;
      end
      repeat (DIV) @(posedge core_clk);
      if (line) gotCnt++;
    end
  end
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench for the host serial port with a host model
// assumes 50 MHz clock; character traffic at the fastest rate
`timescale 1ns/1ps
module tb_top;
  typedef struct packed { logic [1:0] strap; logic [1:0] rate; } row_t;
  row_t rows [4] = '{'{2'h0, 2'h0}, '{2'h1, 2'h1}, '{2'h2, 2'h2}, '{2'h3, 2'h3}};
  logic core_clk = 1'b0, reset_n = 1'b0, master_reset_n = 1'b1, softReset = 1'b0;
  logic testEnable = 1'b0, rate_select_high = 1'b1, rate_select_low = 1'b1, txValid = 1'b0;
  logic [7:0] txData = 8'h00, rxData, gotByte;
  logic serialIn, serialOut, serialOutEn, txReady, rxValid, rxFrameErr, line;
  logic [1:0] activeRate;
  int gotCnt, error_cnt = 0, num_checks = 0, rxCnt = 0, cycles = 0;
  assign line = serialOutEn ? 1'b0 : 1'b1;
  initial forever #10 core_clk = ~core_clk;
  host_serial_port host_serial_port_i (.core_clk, .reset_n, .master_reset_n, .softReset,
    .testEnable, .rate_select_high, .rate_select_low, .serialIn, .serialOut, .serialOutEn,
    .txValid, .txData, .txReady, .rxValid, .rxData, .rxFrameErr, .activeRate);
  host_uart_model host_uart_model_i (.core_clk, .line, .serialIn, .gotByte, .gotCnt);
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // count receive pulses and cut a hang short
  always @(posedge core_clk) begin
    rxCnt += rxValid;
    if (++cycles == 40000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    repeat (3) @(negedge core_clk);
    reset_n = 1'b1;
    // each strap code caught by a master reset, later strap changes ignored
    foreach (rows[i]) begin
      {rate_select_high, rate_select_low} = rows[i].strap;
      master_reset_n = 1'b0;
      repeat (2) @(negedge core_clk);
      master_reset_n = 1'b1;
      repeat (2) @(negedge core_clk);
      {rate_select_high, rate_select_low} = ~rows[i].strap;
      repeat (3) @(negedge core_clk);
      chk({6'h00, activeRate}, {6'h00, rows[i].rate});
    end
    $display("rate rows done");
    testEnable = 1'b1;
    txValid = 1'b1;
    txData = 8'h5a;
    repeat (4) @(negedge core_clk);
    chk({6'h00, serialOutEn, txReady}, 8'h00);
    txValid = 1'b0;
    testEnable = 1'b0;
    {rate_select_high, rate_select_low} = 2'h1;
    repeat (3) @(negedge core_clk);
    {rate_select_high, rate_select_low} = 2'h3;
    softReset = 1'b1;
    @(negedge core_clk);
    softReset = 1'b0;
    repeat (3) @(negedge core_clk);
    chk({6'h00, activeRate}, 8'h03);
    $display("test mode and soft reset done");
    txValid = 1'b1;
    @(negedge core_clk);
    txValid = 1'b0;
    host_uart_model_i.send(8'hff);
    for (int k = 0; k < 3000 && txReady !== 1'b1; k++) @(negedge core_clk);
    chk(gotByte, 8'h5a);
    chk(8'(gotCnt), 8'h01);
    chk(8'(rxCnt), 8'h00);
    $display("transmit done");
    host_uart_model_i.send(8'hc3);
    chk(rxData, 8'hc3);
    chk({7'h00, rxFrameErr}, 8'h00);
    chk(8'(rxCnt), 8'h01);
    $display("receive done");
    results();
  end
endmodule
